// file: hw/nov_pkg.sv
// Package: constants, register map and codes of the residual overvoltage stage
package nov_pkg;
  // Clock and program cycle
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int PROG_CYCLE_US = 5000;
  localparam int PROG_CYCLE_CLKS = PROG_CYCLE_US * (CLK_FREQ_HZ / 1_000_000);
  // Widths
  localparam int VW = 16;
  localparam int TW = 19;
  localparam int DW = 48;
  localparam int QF = 16;
  // Timing limits, in program-cycle steps of 5 ms
  localparam logic [TW-1:0] TIME_MAX_STEPS = 19'h57e40;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THRESH = 8'h04;
  localparam logic [7:0] OFS_DT_DELAY = 8'h08;
  localparam logic [7:0] OFS_DIAL = 8'h0c;
  localparam logic [7:0] OFS_EXPO = 8'h10;
  localparam logic [7:0] OFS_RELEASE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_RATIO = 8'h1c;
  localparam logic [7:0] OFS_EXPECTED = 8'h20;
  localparam logic [7:0] OFS_REMAIN = 8'h24;
  localparam logic [7:0] OFS_BLK_EVT = 8'h28;
  // Control register fields
  localparam int CTRL_DTYPE_LSB = 0;
  localparam int CTRL_DREL_LSB = 2;
  localparam int CTRL_TRST_LSB = 4;
  localparam int CTRL_CONT_LSB = 6;
  localparam int CTRL_MODE_LSB = 8;
  localparam int CTRL_SEL_LSB = 12;
  // Codes
  localparam logic [1:0] DTYPE_DT = 2'h1;
  localparam logic [1:0] DTYPE_IDMT = 2'h2;
  localparam logic [1:0] SEL_NO = 2'h1;
  localparam logic [1:0] SEL_YES = 2'h2;
  localparam logic [2:0] MODE_ON = 3'h1;
  localparam logic [2:0] MODE_BLOCKED = 3'h2;
  localparam logic [2:0] MODE_TEST = 3'h3;
  localparam logic [2:0] MODE_TEST_BLK = 3'h4;
  localparam logic [2:0] MODE_OFF = 3'h5;
  localparam logic [2:0] MSEL_AUTO = 3'h1;
  localparam logic [2:0] MSEL_CALC = 3'h2;
  localparam logic [2:0] MSEL_U3 = 3'h3;
  localparam logic [2:0] MSEL_U4 = 3'h4;
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_CALC = 2'h1;
  localparam logic [1:0] SRC_U3 = 2'h2;
  localparam logic [1:0] SRC_U4 = 2'h3;
  localparam logic [1:0] FAULT_EARTH = 2'h1;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_1169;
  localparam logic [31:0] THRESH_RST = 32'h0000_0064;
  localparam logic [31:0] DT_DELAY_RST = 32'h0000_0008;
  localparam logic [31:0] DIAL_RST = 32'h0000_0005;
  localparam logic [31:0] EXPO_RST = 32'h0000_0064;
  localparam logic [31:0] RELEASE_RST = 32'h0000_000c;
  // Hysteresis, percent
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam logic [7:0] PCT_RELEASE = 8'h61;
  // Fixed-point helpers: 1/100 in Q16, and 5 ms steps per 0.01 s unit
  localparam logic [9:0] INV100_Q16 = 10'h28f;
  localparam logic [1:0] STEPS_PER_CS = 2'h2;
  localparam logic [4:0] EXP_INT_MAX = 5'h1e;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CALC_IDLE = 2'b00,
    CALC_RATIO = 2'b01,
    CALC_TIME = 2'b10
  } calc_state_t;
endpackage

// file: hw/nov_serial_div.sv
// Restoring serial divider, one quotient bit per clock
module nov_serial_div #(
  parameter int W = 48
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request
  input wire logic go_i,
  input wire logic [W-1:0] num_i,
  input wire logic [W-1:0] den_i,
  // Result
  output logic done_o,
  output logic [W-1:0] quot_o
);
  localparam logic [6:0] W_BITS = 7'(W);
  logic [W-1:0] rem_r;
  logic [W-1:0] num_r;
  logic [W-1:0] den_r;
  logic [6:0] cnt_r;
  logic busy_r;
  logic [W:0] trial;

  initial assert (W >= 2 && W <= 64) else $error("divider width out of range");

  assign trial = {rem_r, num_r[W-1]} - {1'b0, den_r};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rem_r <= '0;
      num_r <= '0;
      den_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_o <= 1'b0;
      quot_o <= '0;
    end else begin
      done_o <= 1'b0;
      if (go_i && !busy_r) begin
        rem_r <= '0;
        num_r <= num_i;
        den_r <= den_i;
        cnt_r <= W_BITS;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (!trial[W]) begin
          rem_r <= trial[W-1:0];
        end else begin
          rem_r <= {rem_r[W-2:0], num_r[W-1]};
        end
        num_r <= {num_r[W-2:0], ~trial[W]};
        cnt_r <= cnt_r - 7'h01;
        if (cnt_r == 7'h01) begin
          busy_r <= 1'b0;
          done_o <= 1'b1;
          quot_o <= {num_r[W-2:0], ~trial[W]};
        end
      end
    end
  end
endmodule // nov_serial_div

// file: hw/residual_overvoltage_block.sv
// Residual overvoltage stage: pick-up, blocking check, trip/release timing, AXI4-Lite registers
// Operation
// - Blocking input is sampled once per program cycle and used throughout.
// - Pick-up with blocking inactive raises START and starts delay evaluation.
// - Pick-up with blocking active raises BLOCKED only; no timing or trip.
// - Blocking during START drops START and runs release as on pick-up loss; here START stays held through release when delayed release is 2.
// - Instant operation trips in the same cycle as START.
// - Definite time trips after the set delay while pick-up holds.
// - Inverse time = dial / (ratio to the power of exponent minus one).
// - Delay type 1 definite, 2 inverse; definite after reset.
// - Definite delay in 5 ms steps, default 40 ms; zero means instant.
// - Dial in 0.01 s default 0.05 s; exponent default 1.00; inverse only.
// - Release delay in 5 ms steps, default 60 ms; START held meanwhile with delayed release.
// - Delayed release 1 no, 2 yes: START clears at once or after release.
// - Timer reset after release: counter clears only after full release time.
// - Continue during release keeps the operating counter advancing.
// - While counting during release, no trip unless pick-up returns.
// - Remaining time reported signed, in 5 ms steps.
// - Source code 0 none, 1 calculated, 2/3 dedicated; auto falls back.
// - Measured to threshold ratio reported in 0.01 resolution.
// - Expected operating time reported; inverse value follows the voltage.
// - Becoming blocked issues an event with voltage and fault type, plus indication.
// - Operating mode reported as 1 on to 5 off.
// - Pick-up above threshold, release below 97 percent of it.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
module residual_overvoltage_block
  import nov_pkg::*;
#(
  parameter int CYCLE_CLKS = PROG_CYCLE_CLKS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // AXI4-Lite write address and data
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [7:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // AXI4-Lite write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // AXI4-Lite read
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [7:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // Measurement front end and blocking matrix
  input wire logic [VW-1:0] calc_volt_i,
  input wire logic [VW-1:0] u3_volt_i,
  input wire logic [VW-1:0] u4_volt_i,
  input wire logic u3_residual_mode_i,
  input wire logic u4_residual_mode_i,
  input wire logic ln_connected_i,
  input wire logic block_i,
  // Stage outputs
  output logic start_o,
  output logic trip_o,
  output logic blocked_o,
  output logic block_event_o,
  output logic block_display_o
);
  initial assert (CYCLE_CLKS >= 64) else $error("program cycle shorter than calculation");

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = nw[8*i +: 8];
    end
    return res;
  endfunction

  // Piecewise-linear log2 of a Q16 value at or above one
  function automatic logic [31:0] log2_q16(input logic [DW-1:0] x);
    logic [5:0] msb;
    logic [DW-1:0] sh;
    msb = 6'(QF);
    for (int i = QF; i < DW; i++) begin
      if (x[i]) msb = 6'(i);
    end
    sh = x << (6'(DW - 1) - msb);
    return {10'h000, msb - 6'(QF), sh[DW-2 -: QF]};
  endfunction

  // Piecewise-linear 2^y for Q16 y, saturating at the top
  function automatic logic [DW-1:0] exp2_q16(input logic [31:0] y);
    logic [DW-1:0] mant;
    mant = {31'h0, 1'b1, y[QF-1:0]};
    if (y[31:QF] > 16'(EXP_INT_MAX)) return {DW{1'b1}};
    return mant << y[20:QF];
  endfunction

  // Configuration registers
  logic [31:0] ctrl_r, thresh_r, dt_delay_r, dial_r, expo_r, release_r;
  // Bus state
  logic aw_hold_r, w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  // Stage state
  logic [$clog2(CYCLE_CLKS)-1:0] tick_cnt_r;
  logic tick_r;
  logic eval_r;
  logic blk_s_r;
  logic pickup_r;
  logic running_r;
  logic releasing_r;
  logic [TW-1:0] op_cnt_r, rel_cnt_r;
  logic [VW-1:0] meas_r;
  logic [1:0] src_r;
  logic [TW-1:0] idmt_steps_r;
  logic [31:0] ratio_r;
  logic [VW-1:0] blk_volt_r;
  calc_state_t calc_r;
  // Divider
  logic div_go;
  logic div_done;
  logic [DW-1:0] div_num, div_den, div_quot;

  logic [1:0] dtype, drel, trst, cont;
  logic [2:0] mode, msel;
  logic [TW-1:0] dt_steps, rel_steps, target;
  logic [VW-1:0] meas_sel;
  logic [1:0] src_sel;
  logic pick_now, eff, blk_eff, stage_off, instant, rel_done;
  logic [TW-1:0] op_inc, rel_inc;
  logic [DW-1:0] pw, pm1;

  assign dtype = ctrl_r[CTRL_DTYPE_LSB +: 2];
  assign drel = ctrl_r[CTRL_DREL_LSB +: 2];
  assign trst = ctrl_r[CTRL_TRST_LSB +: 2];
  assign cont = ctrl_r[CTRL_CONT_LSB +: 2];
  assign mode = ctrl_r[CTRL_MODE_LSB +: 3];
  assign msel = ctrl_r[CTRL_SEL_LSB +: 3];
  assign dt_steps = dt_delay_r[TW-1:0];
  assign rel_steps = release_r[TW-1:0];
  assign stage_off = (mode == MODE_OFF);
  assign instant = (dtype != DTYPE_IDMT) && (dt_steps == '0);
  assign target = (dtype == DTYPE_IDMT) ? idmt_steps_r : dt_steps;

  // Source selection with automatic fallback
  always_comb begin
    src_sel = SRC_NONE;
    meas_sel = '0;
    if (msel == MSEL_U3 && u3_residual_mode_i) begin
      src_sel = SRC_U3;
      meas_sel = u3_volt_i;
    end else if (msel == MSEL_U4 && u4_residual_mode_i) begin
      src_sel = SRC_U4;
      meas_sel = u4_volt_i;
    end else if (msel == MSEL_CALC || (msel == MSEL_AUTO && ln_connected_i)) begin
      src_sel = SRC_CALC;
      meas_sel = calc_volt_i;
    end
  end

  // Pick-up with 97 percent release level
  always_comb begin
    if (src_sel == SRC_NONE) begin
      pick_now = 1'b0;
    end else if (pickup_r) begin
      pick_now = (32'(meas_sel) * 32'(PCT_FULL)) >= (32'(thresh_r[VW-1:0]) * 32'(PCT_RELEASE));
    end else begin
      pick_now = meas_sel > thresh_r[VW-1:0];
    end
  end

  // Mode 2 and 4 force blocking; blocking held from the sampled value
  assign blk_eff = blk_s_r || mode == MODE_BLOCKED || mode == MODE_TEST_BLK;
  assign eff = pickup_r && !blk_eff && !stage_off;
  assign op_inc = (op_cnt_r < TIME_MAX_STEPS) ? op_cnt_r + 19'h1 : op_cnt_r;
  assign rel_inc = rel_cnt_r + 19'h1;
  assign rel_done = rel_cnt_r >= rel_steps;

  // Program-cycle tick; blocking sampled at its start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
      eval_r <= 1'b0;
    end else begin
      // Evaluate one clock after sampling, on the settled snapshot
      eval_r <= tick_r;
      tick_r <= 1'b0;
      if (tick_cnt_r == ($clog2(CYCLE_CLKS))'(CYCLE_CLKS - 1)) begin
        tick_cnt_r <= '0;
        tick_r <= 1'b1;
      end else begin
        tick_cnt_r <= tick_cnt_r + 1'b1;
      end
    end
  end

  // Input sampling: the stage then works on one coherent snapshot
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      blk_s_r <= 1'b0;
      pickup_r <= 1'b0;
      meas_r <= '0;
      src_r <= SRC_NONE;
    end else if (tick_r) begin
      blk_s_r <= block_i;
      pickup_r <= pick_now;
      meas_r <= meas_sel;
      src_r <= src_sel;
    end
  end

  // Trip and release timing
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      running_r <= 1'b0;
      releasing_r <= 1'b0;
      op_cnt_r <= '0;
      rel_cnt_r <= '0;
      start_o <= 1'b0;
      trip_o <= 1'b0;
      blocked_o <= 1'b0;
    end else if (eval_r) begin
      blocked_o <= pickup_r && blk_eff && !stage_off && !running_r;
      if (eff) begin
        running_r <= 1'b1;
        releasing_r <= 1'b0;
        rel_cnt_r <= '0;
        start_o <= 1'b1;
        if (instant) begin
          trip_o <= 1'b1;
        end else begin
          op_cnt_r <= op_inc;
          trip_o <= op_cnt_r >= target;
        end
      end else if (running_r) begin
        trip_o <= 1'b0;
        if (trst != SEL_YES && cont != SEL_YES) op_cnt_r <= '0;
        else if (cont == SEL_YES) op_cnt_r <= op_inc;
        if (rel_done || stage_off) begin
          running_r <= 1'b0;
          releasing_r <= 1'b0;
          rel_cnt_r <= '0;
          start_o <= 1'b0;
          op_cnt_r <= '0;
        end else begin
          releasing_r <= 1'b1;
          rel_cnt_r <= rel_inc;
          start_o <= (drel == SEL_YES);
        end
      end else begin
        start_o <= 1'b0;
        trip_o <= 1'b0;
      end
    end
  end

  // Block event: one pulse per new blocked state, with captured voltage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      block_event_o <= 1'b0;
      block_display_o <= 1'b0;
      blk_volt_r <= '0;
    end else begin
      block_event_o <= 1'b0;
      if (pickup_r && blk_eff && !stage_off && !running_r && eval_r && !blocked_o) begin
        block_event_o <= 1'b1;
        block_display_o <= 1'b1;
        blk_volt_r <= meas_r;
      end else if (!blocked_o && !block_event_o) begin
        block_display_o <= 1'b0;
      end
    end
  end

  // Ratio and inverse time, recomputed every program cycle
  assign pw = exp2_q16(32'((48'(log2_q16(div_quot)) * 48'(expo_r[11:0]) * 48'(INV100_Q16)) >> QF));
  assign pm1 = pw - (48'h1 << QF);
  assign div_go = (calc_r == CALC_IDLE && tick_r && thresh_r[VW-1:0] != '0) ||
                  (calc_r == CALC_RATIO && div_done && div_quot > (48'h1 << QF) && pm1 != '0);
  assign div_num = (calc_r == CALC_IDLE) ? (48'(meas_sel) << QF) :
                   ((48'(dial_r[12:0]) * 48'(STEPS_PER_CS)) << QF);
  assign div_den = (calc_r == CALC_IDLE) ? 48'(thresh_r[VW-1:0]) : pm1;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      calc_r <= CALC_IDLE;
      ratio_r <= '0;
      idmt_steps_r <= TIME_MAX_STEPS;
    end else begin
      case (calc_r)
        CALC_IDLE: begin
          if (div_go) calc_r <= CALC_RATIO;
        end
        CALC_RATIO: begin
          if (div_done) begin
            ratio_r <= 32'((div_quot * 48'(PCT_FULL)) >> QF);
            if (div_go) begin
              calc_r <= CALC_TIME;
            end else begin
              idmt_steps_r <= TIME_MAX_STEPS;
              calc_r <= CALC_IDLE;
            end
          end
        end
        CALC_TIME: begin
          if (div_done) begin
            idmt_steps_r <= (div_quot > 48'(TIME_MAX_STEPS)) ? TIME_MAX_STEPS :
                            ((div_quot == '0) ? 19'h1 : div_quot[TW-1:0]);
            calc_r <= CALC_IDLE;
          end
        end
        default: calc_r <= CALC_IDLE;
      endcase
    end
  end

  nov_serial_div #(.W(DW)) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .go_i(div_go),
    .num_i(div_num),
    .den_i(div_den),
    .done_o(div_done),
    .quot_o(div_quot)
  );

  // AXI4-Lite write side; address and data taken in either order
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      awready_o <= 1'b1;
      wready_o <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bvalid_o <= 1'b0;
      bresp_o <= RESP_OKAY;
      ctrl_r <= CTRL_RST;
      thresh_r <= THRESH_RST;
      dt_delay_r <= DT_DELAY_RST;
      dial_r <= DIAL_RST;
      expo_r <= EXPO_RST;
      release_r <= RELEASE_RST;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= awaddr_i;
        awready_o <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        w_hold_r <= 1'b1;
        w_data_r <= wdata_i;
        w_strb_r <= wstrb_i;
        wready_o <= 1'b0;
      end
      if (aw_hold_r && w_hold_r && !bvalid_o) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o <= RESP_OKAY;
        if (aw_addr_r == OFS_CTRL) begin
          ctrl_r <= strb_merge(ctrl_r, w_data_r, w_strb_r);
        end else if (aw_addr_r == OFS_THRESH) begin
          thresh_r <= strb_merge(thresh_r, w_data_r, w_strb_r);
        end else if (aw_addr_r == OFS_DT_DELAY) begin
          dt_delay_r <= strb_merge(dt_delay_r, w_data_r, w_strb_r);
        end else if (aw_addr_r == OFS_DIAL) begin
          dial_r <= strb_merge(dial_r, w_data_r, w_strb_r);
        end else if (aw_addr_r == OFS_EXPO) begin
          expo_r <= strb_merge(expo_r, w_data_r, w_strb_r);
        end else if (aw_addr_r == OFS_RELEASE) begin
          release_r <= strb_merge(release_r, w_data_r, w_strb_r);
        end else begin
          bresp_o <= RESP_SLVERR;
        end
      end
      if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
        awready_o <= 1'b1;
        wready_o <= 1'b1;
      end
    end
  end

  // AXI4-Lite read side
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      arready_o <= 1'b1;
      rvalid_o <= 1'b0;
      rdata_o <= '0;
      rresp_o <= RESP_OKAY;
    end else if (arvalid_i && arready_o) begin
      arready_o <= 1'b0;
      rvalid_o <= 1'b1;
      rresp_o <= RESP_OKAY;
      rdata_o <= '0;
      if (araddr_i == OFS_CTRL) begin
        rdata_o <= ctrl_r;
      end else if (araddr_i == OFS_THRESH) begin
        rdata_o <= thresh_r;
      end else if (araddr_i == OFS_DT_DELAY) begin
        rdata_o <= dt_delay_r;
      end else if (araddr_i == OFS_DIAL) begin
        rdata_o <= dial_r;
      end else if (araddr_i == OFS_EXPO) begin
        rdata_o <= expo_r;
      end else if (araddr_i == OFS_RELEASE) begin
        rdata_o <= release_r;
      end else if (araddr_i == OFS_STATUS) begin
        rdata_o <= {22'h0, mode, src_r, releasing_r, pickup_r, blocked_o, trip_o, start_o};
      end else if (araddr_i == OFS_RATIO) begin
        rdata_o <= ratio_r;
      end else if (araddr_i == OFS_EXPECTED) begin
        rdata_o <= {13'h0, instant ? 19'h0 : target};
      end else if (araddr_i == OFS_REMAIN) begin
        rdata_o <= running_r ? 32'($signed({1'b0, target}) - $signed({1'b0, op_cnt_r})) : '0;
      end else if (araddr_i == OFS_BLK_EVT) begin
        rdata_o <= {14'h0, FAULT_EARTH, blk_volt_r};
      end else begin
        rresp_o <= RESP_SLVERR;
      end
    end else if (rvalid_o && rready_i) begin
      rvalid_o <= 1'b0;
      arready_o <= 1'b1;
    end
  end
endmodule // residual_overvoltage_block

// file: sim/nov_stage_props.sv
// Port-level assertions for the residual overvoltage stage
module nov_stage_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic awready_o,
  input wire logic wready_o,
  input wire logic bvalid_o,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic rvalid_o,
  input wire logic start_o,
  input wire logic trip_o,
  input wire logic blocked_o,
  input wire logic block_event_o,
  input wire logic block_display_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rd_lat;
    $rose(rvalid_o) |-> $past(arvalid_i && arready_o);
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer without a taken address");
  property p_b_busy;
    $rose(bvalid_o) |-> !awready_o && !wready_o;
  endproperty
  a_b_busy: assert property (p_b_busy) else $error("write channels ready during response");
  property p_trip_start;
    trip_o |-> start_o;
  endproperty
  a_trip_start: assert property (p_trip_start) else $error("trip without start");
  property p_blk_excl;
    blocked_o |-> !start_o && !trip_o;
  endproperty
  a_blk_excl: assert property (p_blk_excl) else $error("blocked together with start");
  property p_evt_pulse;
    block_event_o |=> !block_event_o;
  endproperty
  a_evt_pulse: assert property (p_evt_pulse) else $error("block event longer than one cycle");
  property p_evt_disp;
    block_event_o |-> ##[0:1] block_display_o;
  endproperty
  a_evt_disp: assert property (p_evt_disp) else $error("block event without indication");
  property p_start_hold;
    $rose(start_o) |=> $stable(start_o) [*8];
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start changed inside a cycle");
  property p_trip_hold;
    $rose(trip_o) |=> trip_o [*8];
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip changed inside a cycle");
endmodule // nov_stage_props

bind residual_overvoltage_block nov_stage_props u_props (.clk_i(clk_i), .rst_i(rst_i),
  .awready_o(awready_o), .wready_o(wready_o), .bvalid_o(bvalid_o), .arvalid_i(arvalid_i),
  .arready_o(arready_o), .rvalid_o(rvalid_o), .start_o(start_o), .trip_o(trip_o),
  .blocked_o(blocked_o), .block_event_o(block_event_o), .block_display_o(block_display_o));

// file: sim/front_end_model.sv
// Measurement front end and blocking matrix model
module front_end_model
  import nov_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Bench requests
  input wire logic [VW-1:0] level_i,
  input wire logic block_req_i,
  // Toward the stage
  output logic [VW-1:0] calc_volt_o,
  output logic [VW-1:0] u3_volt_o,
  output logic [VW-1:0] u4_volt_o,
  output logic ln_connected_o,
  output logic block_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    calc_volt_o = '0;
    u3_volt_o = 16'h5a5a;
    u4_volt_o = 16'h0f0f;
    ln_connected_o = 1'b1;
    block_o = 1'b0;
  end
  always @(posedge clk_i) begin
    calc_volt_o <= level_i;
    // Unused channels toggle so a wrong source choice shows at once
    u3_volt_o <= ~u3_volt_o;
    u4_volt_o <= ~u4_volt_o;
    block_o <= block_req_i;
  end
endmodule // front_end_model

// file: sim/residual_overvoltage_block_tb.sv
// Self-checking bench of the residual overvoltage stage
module residual_overvoltage_block_tb;
  import nov_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CYC = 200;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic awvalid_i = 1'b0, wvalid_i = 1'b0, arvalid_i = 1'b0;
  logic [7:0] awaddr_i = '0, araddr_i = '0;
  logic [31:0] wdata_i = '0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [1:0] bresp_o, rresp_o, r;
  logic [31:0] rdata_o, d;
  logic [VW-1:0] lvl = '0, calc_v, u3_v, u4_v;
  logic blk = 1'b0, ln_c, blk_w, start_o, trip_o, blocked_o, block_event_o, block_display_o;
  int failures = 0, n_checks = 0;
  always #25 clk_i = ~clk_i;
  front_end_model u_fe (.clk_i(clk_i), .level_i(lvl), .block_req_i(blk), .calc_volt_o(calc_v),
    .u3_volt_o(u3_v), .u4_volt_o(u4_v), .ln_connected_o(ln_c), .block_o(blk_w));
  residual_overvoltage_block #(.CYCLE_CLKS(CYC)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .awvalid_i(awvalid_i), .awready_o(awready_o), .awaddr_i(awaddr_i), .wvalid_i(wvalid_i),
    .wready_o(wready_o), .wdata_i(wdata_i), .wstrb_i(4'hf), .bvalid_o(bvalid_o),
    .bready_i(1'b1), .bresp_o(bresp_o), .arvalid_i(arvalid_i), .arready_o(arready_o),
    .araddr_i(araddr_i), .rvalid_o(rvalid_o), .rready_i(1'b1), .rdata_o(rdata_o),
    .rresp_o(rresp_o), .calc_volt_i(calc_v), .u3_volt_i(u3_v), .u4_volt_i(u4_v),
    .u3_residual_mode_i(1'b0), .u4_residual_mode_i(1'b0), .ln_connected_i(ln_c),
    .block_i(blk_w), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o),
    .block_event_o(block_event_o), .block_display_o(block_display_o));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Ready responses are always accepted, so bready/rready stay high
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr_i <= a;
    wdata_i <= v;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    while (aw || w) begin
      @(posedge clk_i);
      if (aw && awready_o) begin
        aw = 1'b0;
        awvalid_i <= 1'b0;
      end
      if (w && wready_o) begin
        w = 1'b0;
        wvalid_i <= 1'b0;
      end
    end
    do @(posedge clk_i); while (bvalid_o !== 1'b1);
    rs = bresp_o;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    do @(posedge clk_i); while (arready_o !== 1'b1);
    arvalid_i <= 1'b0;
    do @(posedge clk_i); while (rvalid_o !== 1'b1);
    v = rdata_o;
    rs = rresp_o;
  endtask
  task automatic regs();
    logic [7:0] ofs [5] = '{OFS_DT_DELAY, OFS_DIAL, OFS_EXPO, OFS_RELEASE, OFS_CTRL};
    logic [31:0] exp [5] = '{32'h8, 32'h5, 32'h64, 32'hc, 32'h0000_1169};
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], d, r);
      chk("reset value", d, exp[i]);
    end
    rd(8'h40, d, r);
    chk("unmapped read", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(OFS_STATUS, 32'h0, r);
    chk("read-only write", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(OFS_CTRL, 32'h0000_1169, r);
  endtask
  task automatic dt_trip();
    int n;
    lvl <= 16'h0096;
    while (start_o !== 1'b1) @(posedge clk_i);
    for (n = 0; trip_o !== 1'b1; n++) @(posedge clk_i);
    chk("definite delay", 32'(n), 32'(8 * CYC));
    rd(OFS_RATIO, d, r);
    chk("ratio", d, 32'h96);
    rd(OFS_STATUS, d, r);
    chk("status", d & 32'h3ef, 32'hab);
    rd(OFS_EXPECTED, d, r);
    chk("expected time", d, 32'h8);
    lvl <= '0;
    while (trip_o !== 1'b0) @(posedge clk_i);
    for (n = 0; start_o !== 1'b0; n++) @(posedge clk_i);
    chk("release hold", 32'(n), 32'(12 * CYC));
  endtask
  task automatic instant();
    wr(OFS_DT_DELAY, 32'h0, r);
    wr(OFS_CTRL, 32'h0000_1165, r);
    lvl <= 16'h0096;
    while (start_o !== 1'b1) @(posedge clk_i);
    chk("instant trip", {31'h0, trip_o}, 32'h1);
    lvl <= '0;
    while (trip_o !== 1'b0) @(posedge clk_i);
    chk("undelayed release", {31'h0, start_o}, 32'h0);
    wr(OFS_DT_DELAY, 32'h8, r);
    wr(OFS_CTRL, 32'h0000_1169, r);
  endtask
  task automatic blocking();
    logic ev;
    ev = 1'b0;
    blk <= 1'b1;
    repeat (2 * CYC) @(posedge clk_i);
    lvl <= 16'h00c8;
    while (blocked_o !== 1'b1) @(posedge clk_i);
    ev = (block_event_o === 1'b1);
    repeat (4) begin
      @(posedge clk_i);
      ev = ev | (block_event_o === 1'b1);
    end
    chk("no start when blocked", {31'h0, start_o}, 32'h0);
    chk("block event", {31'h0, ev}, 32'h1);
    chk("block display", {31'h0, block_display_o}, 32'h1);
    rd(OFS_BLK_EVT, d, r);
    chk("event data", d, {14'h0, FAULT_EARTH, 16'h00c8});
    lvl <= '0;
    blk <= 1'b0;
    repeat (3 * CYC) @(posedge clk_i);
  endtask
  task automatic block_running();
    logic tr;
    tr = 1'b0;
    lvl <= 16'h0096;
    while (start_o !== 1'b1) @(posedge clk_i);
    blk <= 1'b1;
    // Release runs longer than the delay, so counting must hold
    while (start_o !== 1'b0) begin
      @(posedge clk_i);
      tr = tr | (trip_o === 1'b1);
    end
    chk("trip after late block", {31'h0, tr}, 32'h0);
    lvl <= '0;
    blk <= 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    regs();
    dt_trip();
    instant();
    blocking();
    block_running();
    close_out();
  end
  initial begin
    repeat (80 * CYC) @(posedge clk_i);
    failures++;
    close_out();
  end
endmodule // residual_overvoltage_block_tb
